/* rtl/vfg_gate.sv */
`timescale 1ns/1ps
module vfg_gate
    import vfg_pkg::*;
(
    input  wire logic      clk,           // 200 MHz core clock
    input  wire logic      reset,         // Asynchronous, active high
    input  wire logic      clk_en,        // Freezes all state while low
    input  wire vfg_caps_t caps,          // Implemented groups, same clock domain
    input  wire logic      os_enabled,    // Operating system turned on state saving
    input  wire logic      privileged,    // Current level is privileged
    input  wire logic      user_read_en,  // Control read allowed at user level
    input  wire logic      req_valid,     // Instruction presented this cycle
    input  wire vfg_req_t  req,           // Decoded instruction
    output vfg_rsp_t       rsp,           // Registered outcome, one cycle later
    output logic [63:0]    ext_state_enable_reg // Current enable register
);
    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    logic [63:0] xse;
    wire logic   legal_ud;

    vfg_legality u_legal (
        .req  (req),
        .caps (caps),
        .xse  (xse),
        .ud   (legal_ud)
    );

    function automatic logic [31:0] leaf7_b(input vfg_caps_t c);
        logic [31:0] b;
        b = 32'h0000_0000;
        b[BIT_FOUNDATION]  = c.foundation;
        b[BIT_DWORD_QWORD] = c.dword_qw;
        b[BIT_GATHER_PF]   = c.gather_pf;
        b[BIT_EXP_RECIP]   = c.exp_recip;
        b[BIT_CONFLICT]    = c.conflict;
        b[BIT_BYTE_WORD]   = c.byte_word;
        b[BIT_REDUCED_LEN] = c.reduced_len;
        return b;
    endfunction

    // ------------------------------------------------------------------
    // Enumeration results
    // ------------------------------------------------------------------
    // The OS flag only shows when the save machinery exists behind it.
    wire logic        os_flag  = os_enabled & caps.state_save;
    wire logic        op_enum  = (req.op == VFG_OP_ENUM);
    wire logic        is_leaf7 = (req.leaf == LEAF_EXT_FEATURE) && (req.subleaf == SUBLEAF_ZERO);
    wire logic        is_leaf1 = (req.leaf == LEAF_BASIC);
    wire logic [31:0] os_bit   = 32'h0000_0001 << BIT_OS_STATE_SAVE;
    // Leaves that are not modelled answer with zeros, never with stale flags.
    wire logic [31:0] enum_b   = (op_enum && is_leaf7) ? leaf7_b(caps) : 32'h0000_0000;
    wire logic [31:0] enum_c   = (op_enum && is_leaf1 && os_flag) ? os_bit : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Extended-control access and fault priority
    // ------------------------------------------------------------------
    // A write that would disable the base legacy state bit is refused.
    wire logic wr_op  = (req.op == VFG_OP_CTRL_WRITE);
    wire logic rd_op  = (req.op == VFG_OP_CTRL_READ);
    wire logic gp_wr  = wr_op && (!privileged || !req.wdata[0]);
    wire logic gp_rd  = rd_op && !privileged && !user_read_en;
    wire logic ud_now = legal_ud;
    // An invalid opcode outranks the privilege fault, so no instruction reports both.
    wire logic gp_now = !ud_now && (gp_wr || gp_rd);
    wire logic do_wr  = req_valid && wr_op && !ud_now && !gp_wr;
    wire logic rd_ok  = rd_op && !ud_now && !gp_rd;

    // ------------------------------------------------------------------
    // Next outcome
    // ------------------------------------------------------------------
    // The result words follow the request even without the strobe; only the
    // strobe-qualified flags tell a consumer whether the words mean anything.
    wire logic        next_valid = req_valid;
    wire logic        next_ud    = req_valid && ud_now;
    wire logic        next_gp    = req_valid && gp_now;
    wire logic        next_exec  = req_valid && !ud_now && !gp_now;
    wire logic [63:0] next_rdata = rd_ok ? xse : 64'h0000_0000_0000_0000;
    wire logic [63:0] next_xse   = do_wr ? req.wdata : xse;

    // ------------------------------------------------------------------
    // Registered outcome
    // ------------------------------------------------------------------
    logic        out_valid;
    logic        out_ud;
    logic        out_gp;
    logic        out_exec;
    logic [31:0] out_res_b;
    logic [31:0] out_res_c;
    logic [63:0] out_rdata;

    // Every field of the outcome is a flip-flop; the struct is only wiring.
    assign rsp = {out_valid, out_ud, out_gp, out_exec, out_res_b, out_res_c, out_rdata};

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Each register is gated by the clock enable alone, so a low enable holds
    // the whole outcome exactly as the last enabled edge left it.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            xse <= XSE_RESET;
        end else if (clk_en) begin
            xse <= next_xse;
        end
    end

    // The port copy is a separate flip-flop so that the output never sees the decode path.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_state_enable_reg <= XSE_RESET;
        end else if (clk_en) begin
            ext_state_enable_reg <= next_xse;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_valid <= 1'b0;
        end else if (clk_en) begin
            out_valid <= next_valid;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_ud <= 1'b0;
        end else if (clk_en) begin
            out_ud <= next_ud;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_gp <= 1'b0;
        end else if (clk_en) begin
            out_gp <= next_gp;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_exec <= 1'b0;
        end else if (clk_en) begin
            out_exec <= next_exec;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_res_b <= 32'h0000_0000;
        end else if (clk_en) begin
            out_res_b <= enum_b;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_res_c <= 32'h0000_0000;
        end else if (clk_en) begin
            out_res_c <= enum_c;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_rdata <= 64'h0000_0000_0000_0000;
        end else if (clk_en) begin
            out_rdata <= next_rdata;
        end
    end
endmodule

/* rtl/vfg_pkg.sv */
package vfg_pkg;

    // ------------------------------------------------------------------
    // Enumeration leaf numbers and result bit positions
    // ------------------------------------------------------------------
    localparam logic [31:0] LEAF_BASIC       = 32'h0000_0001;
    localparam logic [31:0] LEAF_EXT_FEATURE = 32'h0000_0007;
    localparam logic [31:0] SUBLEAF_ZERO     = 32'h0000_0000;
    localparam int BIT_FOUNDATION    = 16;
    localparam int BIT_DWORD_QWORD   = 17;
    localparam int BIT_GATHER_PF     = 26;
    localparam int BIT_EXP_RECIP     = 27;
    localparam int BIT_CONFLICT      = 28;
    localparam int BIT_BYTE_WORD     = 30;
    localparam int BIT_REDUCED_LEN   = 31;
    localparam int BIT_OS_STATE_SAVE = 27;

    // ------------------------------------------------------------------
    // Extended-state enable register fields
    // ------------------------------------------------------------------
    localparam int          XSE_WIDTH      = 64;
    localparam int          XSE_LOW_LSB    = 1;
    localparam int          XSE_HIGH_LSB   = 5;
    localparam logic [1:0]  XSE_LOW_NEED   = 2'h3;
    localparam logic [2:0]  XSE_HIGH_NEED  = 3'h7;
    localparam logic [63:0] XSE_RESET      = 64'h0000_0000_0000_0001;

    // ------------------------------------------------------------------
    // Vector length field encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        VFG_LEN_128 = 2'h0,
        VFG_LEN_256 = 2'h1,
        VFG_LEN_512 = 2'h2,
        VFG_LEN_RSV = 2'h3
    } vfg_len_t;

    typedef enum logic [2:0] {
        VFG_GRP_FOUNDATION = 3'h0,
        VFG_GRP_EXP_RECIP  = 3'h1,
        VFG_GRP_GATHER_PF  = 3'h2,
        VFG_GRP_CONFLICT   = 3'h3,
        VFG_GRP_DWORD_QW   = 3'h4,
        VFG_GRP_BYTE_WORD  = 3'h5,
        VFG_GRP_NONE       = 3'h6
    } vfg_group_t;

    typedef enum logic [2:0] {
        VFG_OP_VECTOR     = 3'h0,
        VFG_OP_STATE_SAVE = 3'h1,
        VFG_OP_STATE_REST = 3'h2,
        VFG_OP_CTRL_READ  = 3'h3,
        VFG_OP_CTRL_WRITE = 3'h4,
        VFG_OP_WPF_HINT   = 3'h5,
        VFG_OP_ENUM       = 3'h6
    } vfg_op_t;

    // Decoded instruction handed to the gate.
    typedef struct packed {
        vfg_op_t    op;
        vfg_group_t group;
        vfg_len_t   vlen;
        logic       no_128;        // Permute/shuffle/broadcast/extract/insert form.
        logic [31:0] leaf;
        logic [31:0] subleaf;
        logic [63:0] wdata;        // Value for an extended-control write.
    } vfg_req_t;

    // Outcome of one instruction.
    typedef struct packed {
        logic        valid;
        logic        fault_ud;
        logic        fault_gp;
        logic        exec;
        logic [31:0] res_b;
        logic [31:0] res_c;
        logic [63:0] rdata;
    } vfg_rsp_t;

    // Which groups the core implements.
    typedef struct packed {
        logic foundation;
        logic exp_recip;
        logic gather_pf;
        logic conflict;
        logic dword_qw;
        logic byte_word;
        logic reduced_len;
        logic state_save;
    } vfg_caps_t;

endpackage

/* rtl/vfg_legality.sv */
`timescale 1ns/1ps
module vfg_legality
    import vfg_pkg::*;
(
    input  wire vfg_req_t  req,      // Decoded instruction
    input  wire vfg_caps_t caps,     // Implemented groups
    input  wire logic [63:0] xse,    // Extended-state enable register
    output logic           ud        // Invalid-opcode decision
);
    function automatic logic group_flag(input vfg_group_t g, input vfg_caps_t c);
        case (g)
            VFG_GRP_FOUNDATION: group_flag = c.foundation;
            VFG_GRP_EXP_RECIP:  group_flag = c.exp_recip;
            VFG_GRP_GATHER_PF:  group_flag = c.gather_pf;
            VFG_GRP_CONFLICT:   group_flag = c.conflict;
            VFG_GRP_DWORD_QW:   group_flag = c.dword_qw;
            VFG_GRP_BYTE_WORD:  group_flag = c.byte_word;
            default:            group_flag = 1'b0;
        endcase
    endfunction

    wire logic grp_ok   = caps.foundation & group_flag(req.group, caps);
    wire logic state_ok = (xse[XSE_LOW_LSB +: 2] == XSE_LOW_NEED) &&
                          (xse[XSE_HIGH_LSB +: 3] == XSE_HIGH_NEED);
    // Shorter lengths need the reduced-length support; some forms never take 128.
    wire logic len_ok   = (req.vlen == VFG_LEN_512) ||
                          (req.vlen == VFG_LEN_256 && caps.reduced_len) ||
                          (req.vlen == VFG_LEN_128 && caps.reduced_len && !req.no_128);
    // Length limits apply only to sibling groups with a reduced-length form.
    // The exponential and prefetch groups exist at full length only.
    wire logic len_need = (req.group != VFG_GRP_EXP_RECIP) && (req.group != VFG_GRP_GATHER_PF);
    wire logic len_fit  = len_need ? len_ok : (req.vlen == VFG_LEN_512);
    wire logic sv_ok    = caps.state_save && xse[0];

    always_comb begin
        case (req.op)
            VFG_OP_VECTOR:     ud = !(grp_ok && state_ok && len_fit);
            VFG_OP_STATE_SAVE,
            VFG_OP_STATE_REST,
            VFG_OP_CTRL_READ,
            VFG_OP_CTRL_WRITE: ud = !sv_ok;
            VFG_OP_WPF_HINT:   ud = !caps.gather_pf;
            VFG_OP_ENUM:       ud = 1'b0;
            default:           ud = 1'b1;
        endcase
    end
endmodule

/* tb/vfg_gate_sva.sv */
`timescale 1ns/1ps
module vfg_gate_chk
    import vfg_pkg::*;
(
    input wire logic        clk,                  // Core clock
    input wire logic        reset,                // Async reset
    input wire logic        clk_en,               // Run enable
    input wire vfg_caps_t   caps,                 // Implemented groups
    input wire logic        os_enabled,           // OS state saving on
    input wire logic        privileged,           // Privileged level
    input wire logic        user_read_en,         // User control read
    input wire logic        req_valid,            // Request strobe
    input wire vfg_req_t    req,                  // Request
    input wire vfg_rsp_t    rsp,                  // Outcome
    input wire logic [63:0] ext_state_enable_reg  // Enable register
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire take = clk_en && req_valid;
    wire en7  = take && req.op == VFG_OP_ENUM && req.leaf == LEAF_EXT_FEATURE && req.subleaf == SUBLEAF_ZERO;
    wire vec  = take && req.op == VFG_OP_VECTOR;
    a_resp_latency: assert property (take |=> rsp.valid)
        else $error("no response after request");
    a_idle_quiet: assert property (clk_en && !req_valid |=> !rsp.valid)
        else $error("response without request");
    a_exp_flag: assert property (en7 |=> rsp.res_b[27] == $past(caps.exp_recip))
        else $error("exponential flag wrong");
    a_prefetch_flag: assert property (en7 |=> rsp.res_b[26] == $past(caps.gather_pf))
        else $error("prefetch flag wrong");
    a_sibling_flags: assert property (en7 |=> rsp.res_b[16] == $past(caps.foundation)
        && rsp.res_b[17] == $past(caps.dword_qw) && rsp.res_b[28] == $past(caps.conflict)
        && rsp.res_b[30] == $past(caps.byte_word)) else $error("sibling flags wrong");
    a_reduced_flag: assert property (en7 |=> rsp.res_b[31] == $past(caps.reduced_len))
        else $error("reduced length flag wrong");
    a_priv_write: assert property (take && req.op == VFG_OP_CTRL_WRITE && !privileged |=> !rsp.exec)
        else $error("user write executed");
    a_no128_form: assert property (vec && req.no_128 && req.vlen == VFG_LEN_128 |=> rsp.fault_ud)
        else $error("short form accepted");
    a_no_found: assert property (vec && !caps.foundation |=> rsp.fault_ud)
        else $error("vector without foundation");
    a_hint_runs: assert property (take && req.op == VFG_OP_WPF_HINT && caps.gather_pf |=> rsp.exec)
        else $error("hint refused");
    a_full_only: assert property (vec && (req.group == VFG_GRP_EXP_RECIP || req.group == VFG_GRP_GATHER_PF)
        && req.vlen != VFG_LEN_512 |=> rsp.fault_ud) else $error("short length on full-length group");
    a_os_flag: assert property (take && req.op == VFG_OP_ENUM && req.leaf == LEAF_BASIC
        |=> rsp.res_c[27] == $past(os_enabled && caps.state_save)) else $error("state save flag wrong");
    a_state_gate: assert property (vec && (ext_state_enable_reg[7:5] != 3'h7
        || ext_state_enable_reg[2:1] != 2'h3) |=> rsp.fault_ud) else $error("vector ran without enabled state");
    a_freeze: assert property (!clk_en |=> $stable(rsp) && $stable(ext_state_enable_reg))
        else $error("state moved while disabled");
endmodule
bind vfg_gate vfg_gate_chk chk_i (.clk(clk), .reset(reset), .clk_en(clk_en), .caps(caps), .os_enabled(os_enabled),
    .privileged(privileged), .user_read_en(user_read_en), .req_valid(req_valid), .req(req), .rsp(rsp),
    .ext_state_enable_reg(ext_state_enable_reg));

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import vfg_pkg::*;
;
    logic clk = 0, reset = 1, clk_en = 1, os_enabled = 1, privileged = 1, user_read_en = 0, req_valid = 0;
    vfg_caps_t   caps = 8'hff;
    vfg_req_t    req = '0;
    vfg_rsp_t    rsp;
    logic [63:0] xse;
    int          bad_count = 0;
    int          cmp_count = 0;
    always #2.5 clk = ~clk;
    vfg_gate uut (.clk(clk), .reset(reset), .clk_en(clk_en), .caps(caps), .os_enabled(os_enabled),
        .privileged(privileged), .user_read_en(user_read_en), .req_valid(req_valid), .req(req), .rsp(rsp),
        .ext_state_enable_reg(xse));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input vfg_op_t op, input vfg_group_t g, input vfg_len_t l, input logic n,
                       input logic [31:0] leaf, input logic [63:0] wd);
        @(posedge clk);
        req <= '{op, g, l, n, leaf, SUBLEAF_ZERO, wd};
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
    endtask
    task automatic vec(input vfg_group_t g, input vfg_len_t l, input logic n, input logic ud);
        run(VFG_OP_VECTOR, g, l, n, 32'h0, 64'h0);
        chk(rsp.valid, 1'b1);
        chk(rsp.fault_ud, ud);
    endtask
    function automatic logic [31:0] exp_b(input vfg_caps_t c);
        exp_b = '0;
        exp_b[BIT_FOUNDATION] = c.foundation;
        exp_b[BIT_DWORD_QWORD] = c.dword_qw;
        exp_b[BIT_GATHER_PF] = c.gather_pf;
        exp_b[BIT_EXP_RECIP] = c.exp_recip;
        exp_b[BIT_CONFLICT] = c.conflict;
        exp_b[BIT_BYTE_WORD] = c.byte_word;
        exp_b[BIT_REDUCED_LEN] = c.reduced_len;
    endfunction
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #3000;
        bad_count++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(xse, 64'h1);
        for (int i = 0; i < 8; i++) begin
            caps <= 8'h1 << i;
            run(VFG_OP_ENUM, VFG_GRP_NONE, VFG_LEN_512, 1'b0, LEAF_EXT_FEATURE, 64'h0);
            chk(rsp.res_b & 32'hdc03_0000, exp_b(caps));
        end
        for (int i = 0; i < 4; i++) begin
            caps <= {7'h7f, i[0]};
            os_enabled <= i[1];
            run(VFG_OP_ENUM, VFG_GRP_NONE, VFG_LEN_512, 1'b0, LEAF_BASIC, 64'h0);
            chk(rsp.res_c[BIT_OS_STATE_SAVE], i[0] & i[1]);
        end
        caps <= 8'hff;
        run(VFG_OP_CTRL_WRITE, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'he7);
        chk(xse, 64'he7);
        privileged <= 1'b0;
        run(VFG_OP_CTRL_WRITE, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'h7);
        chk(rsp.fault_gp, 1'b1);
        chk(xse, 64'he7);
        run(VFG_OP_CTRL_READ, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'h0);
        chk(rsp.fault_gp, 1'b1);
        user_read_en <= 1'b1;
        run(VFG_OP_CTRL_READ, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'h0);
        chk(rsp.rdata, 64'he7);
        vec(VFG_GRP_FOUNDATION, VFG_LEN_512, 1'b0, 1'b0);
        vec(VFG_GRP_CONFLICT, VFG_LEN_256, 1'b0, 1'b0);
        vec(VFG_GRP_DWORD_QW, VFG_LEN_128, 1'b0, 1'b0);
        vec(VFG_GRP_FOUNDATION, VFG_LEN_128, 1'b1, 1'b1);
        vec(VFG_GRP_DWORD_QW, VFG_LEN_256, 1'b1, 1'b0);
        vec(VFG_GRP_EXP_RECIP, VFG_LEN_512, 1'b0, 1'b0);
        vec(VFG_GRP_EXP_RECIP, VFG_LEN_256, 1'b0, 1'b1);
        vec(VFG_GRP_GATHER_PF, VFG_LEN_512, 1'b0, 1'b0);
        vec(VFG_GRP_GATHER_PF, VFG_LEN_128, 1'b0, 1'b1);
        vec(VFG_GRP_NONE, VFG_LEN_512, 1'b0, 1'b1);
        vec(VFG_GRP_BYTE_WORD, VFG_LEN_RSV, 1'b0, 1'b1);
        caps <= 8'hfd;
        vec(VFG_GRP_CONFLICT, VFG_LEN_256, 1'b0, 1'b1);
        vec(VFG_GRP_CONFLICT, VFG_LEN_512, 1'b0, 1'b0);
        caps <= 8'h7f;
        vec(VFG_GRP_BYTE_WORD, VFG_LEN_512, 1'b0, 1'b1);
        vec(VFG_GRP_DWORD_QW, VFG_LEN_256, 1'b0, 1'b1);
        vec(VFG_GRP_EXP_RECIP, VFG_LEN_512, 1'b0, 1'b1);
        caps <= 8'hef;
        vec(VFG_GRP_CONFLICT, VFG_LEN_512, 1'b0, 1'b1);
        vec(VFG_GRP_CONFLICT, VFG_LEN_256, 1'b0, 1'b1);
        caps <= 8'hf7;
        vec(VFG_GRP_DWORD_QW, VFG_LEN_512, 1'b0, 1'b1);
        caps <= 8'hdf;
        vec(VFG_GRP_GATHER_PF, VFG_LEN_512, 1'b0, 1'b1);
        run(VFG_OP_WPF_HINT, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'h0);
        chk(rsp.fault_ud, 1'b1);
        caps <= 8'hbf;
        vec(VFG_GRP_EXP_RECIP, VFG_LEN_512, 1'b0, 1'b1);
        caps <= 8'hff;
        privileged <= 1'b1;
        run(VFG_OP_STATE_SAVE, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'h0);
        chk(rsp.exec, 1'b1);
        run(VFG_OP_CTRL_WRITE, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'he6);
        chk(rsp.fault_gp, 1'b1);
        run(VFG_OP_CTRL_WRITE, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'he1);
        vec(VFG_GRP_FOUNDATION, VFG_LEN_512, 1'b0, 1'b1);
        run(VFG_OP_CTRL_WRITE, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'h7);
        vec(VFG_GRP_FOUNDATION, VFG_LEN_512, 1'b0, 1'b1);
        run(VFG_OP_WPF_HINT, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'h0);
        chk(rsp.exec, 1'b1);
        clk_en <= 1'b0;
        run(VFG_OP_CTRL_WRITE, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'he7);
        chk(xse, 64'h7);
        chk(rsp.exec, 1'b1);
        clk_en <= 1'b1;
        caps <= 8'hfe;
        run(VFG_OP_STATE_REST, VFG_GRP_NONE, VFG_LEN_512, 1'b0, 32'h0, 64'h0);
        chk(rsp.fault_ud, 1'b1);
        results();
    end
endmodule
